// ---- rbo_pkg.sv ----
package rbo_pkg;
    // operation codes
    localparam logic [7:0] RBO_OP_ROTATE_LEFT  = 8'hEB;
    localparam logic [7:0] RBO_OP_ROTATE_RIGHT = 8'hEA;
    localparam logic [7:0] RBO_OP_TEST_AND_SET = 8'hE0;
    localparam logic [7:0] RBO_OP_BIT_TEST     = 8'h74;
    localparam logic [7:0] RBO_OP_BIT_SET      = 8'h75;
    localparam logic [7:0] RBO_OP_BIT_CLEAR    = 8'h76;

    // widths
    localparam int RBO_DATA_W  = 32;
    localparam int RBO_ADDR_W  = 24;
    localparam int RBO_CNT_W   = 5;
    localparam int RBO_RADDR_W = 4;

    // condition code bit positions: C V G L
    localparam int RBO_CC_C = 3;
    localparam int RBO_CC_V = 2;
    localparam int RBO_CC_G = 1;
    localparam int RBO_CC_L = 0;

    // register offsets
    localparam logic [3:0] RBO_CTRL_OFS   = 4'h0;
    localparam logic [3:0] RBO_STATUS_OFS = 4'h4;
    localparam logic [3:0] RBO_COUNT_OFS  = 4'h8;

    // register fields
    localparam int RBO_CTRL_EN_BIT   = 0;
    localparam int RBO_ST_BUSY_BIT   = 0;
    localparam int RBO_ST_ILL_BIT    = 1;
    localparam int RBO_ST_CC_LSB     = 4;
    localparam logic RBO_CTRL_EN_RST = 1'b1;

    // bit selection inside a byte / halfword
    localparam int RBO_BYTE_SHIFT = 3;
    localparam int RBO_HALF_MSB   = 15;

    // one-hot sequencer states
    typedef enum logic [2:0] {
        RBO_ST_IDLE  = 3'b001,
        RBO_ST_READ  = 3'b010,
        RBO_ST_WRITE = 3'b100
    } rbo_state_e;
endpackage

// ---- rbo_unit.sv ----
`timescale 1ns/10ps
// Functional notes
// - opcode EB decodes as rotate left of the first operand register
// - rotate left moves bits toward msb, bit 31 wraps into bit 0
// - opcode EA rotates right, bit 0 wraps into bit 31
// - rotate count is only the low five bits of operand two
// - rotate clears C and V, L for negative, G for positive
// - zero count leaves register as is, flags still follow its value
// - opcode E0 reads a halfword and writes it back with msb set, atomically
// - test-and-set keeps all other halfword bits
// - test-and-set puts the old msb into L, other flags undefined
// - bit ops use operand two as array base, register as bit offset
// - array bit 0 is the msb of the first byte
// - opcode 74 tests a bit, memory and register untouched
// - opcode 75 writes back the byte with the bit forced to one
// - opcode 76 writes back the byte with the bit forced to zero
// - bit clear clears C V L, G reflects the old bit
module rbo_unit #(
    parameter int ADDR_W = rbo_pkg::RBO_ADDR_W
) (
    // clock and reset
    input  wire logic                               sys_clk_i,
    input  wire logic                               rst_b_i,
    // instruction request from the sequencer
    input  wire logic                               instr_valid_i,
    input  wire logic [7:0]                         opcode_i,
    input  wire logic [rbo_pkg::RBO_DATA_W-1:0]     first_operand_register_i,
    input  wire logic [rbo_pkg::RBO_DATA_W-1:0]     operand2_i,
    // instruction completion
    output logic                                    busy_o,
    output logic                                    done_o,
    output logic                                    illegal_o,
    output logic [3:0]                              cc_o,
    output logic                                    rf_we_o,
    output logic [rbo_pkg::RBO_DATA_W-1:0]          rf_wdata_o,
    // main memory port
    output logic                                    mem_req_o,
    output logic                                    mem_we_o,
    output logic                                    mem_half_o,
    output logic                                    mem_lock_o,
    output logic [ADDR_W-1:0]                       mem_addr_o,
    output logic [15:0]                             mem_wdata_o,
    input  wire logic                               mem_ack_i,
    input  wire logic [15:0]                        mem_rdata_i,
    // register port
    input  wire logic [rbo_pkg::RBO_RADDR_W-1:0]    reg_addr_i,
    input  wire logic [31:0]                        reg_wdata_i,
    input  wire logic                               reg_wr_i,
    input  wire logic                               reg_rd_i,
    output logic [31:0]                             reg_rdata_o
);
    import rbo_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    rbo_state_e               state_reg;
    logic [7:0]               op_reg, byte_reg;
    logic                     ctrl_en_reg, ill_sticky_reg;
    logic [31:0]              count_reg;
    logic                     accept, is_rol, is_ror, is_ts, is_bit, is_legal, old_bit;
    logic [RBO_CNT_W-1:0]     rot_cnt;
    logic [63:0]              rol_wide, ror_wide;
    logic [31:0]              rot_res;
    logic [ADDR_W-1:0]        byte_addr;
    logic [2:0]               bit_sel;
    logic [7:0]               bit_mask;

    assign accept = instr_valid_i && (state_reg == RBO_ST_IDLE) && !busy_o;

    assign is_rol = (opcode_i == RBO_OP_ROTATE_LEFT);
    assign is_ror = (opcode_i == RBO_OP_ROTATE_RIGHT);
    assign is_ts  = (opcode_i == RBO_OP_TEST_AND_SET);
    assign is_bit = (opcode_i == RBO_OP_BIT_TEST) || (opcode_i == RBO_OP_BIT_SET)
                  || (opcode_i == RBO_OP_BIT_CLEAR);
    // a disabled unit refuses everything so the sequencer still gets an answer
    assign is_legal = ctrl_en_reg && (is_rol || is_ror || is_ts || is_bit);

    ////////////////////////////////////////////////////////////////////////////
    // rotate datapath
    // only five count bits
    assign rot_cnt  = operand2_i[RBO_CNT_W-1:0];
    // doubled word shifted gives end-around move without a barrel mux tree per count
    // left wraps msb into lsb, right wraps lsb into msb
    assign rol_wide = {first_operand_register_i, first_operand_register_i} << rot_cnt;
    assign ror_wide = {first_operand_register_i, first_operand_register_i} >> rot_cnt;
    // zero count yields the value itself
    assign rot_res  = is_rol ? rol_wide[63:32] : ror_wide[31:0];

    ////////////////////////////////////////////////////////////////////////////
    // bit array addressing
    // base plus register offset
    // byte offset is offset/8; offset treated as unsigned
    assign byte_addr = operand2_i[ADDR_W-1:0]
                     + ADDR_W'(first_operand_register_i >> RBO_BYTE_SHIFT);
    // bit 0 is msb, so invert the low three bits
    assign bit_sel   = 3'd7 - first_operand_register_i[2:0];
    assign bit_mask  = 8'h01 << bit_sel;
    assign old_bit   = |(mem_rdata_i[7:0] & byte_reg);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer state
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= RBO_ST_IDLE;
        end else begin
            case (state_reg)
                RBO_ST_IDLE: begin
                    if (accept && is_legal && (is_ts || is_bit)) begin
                        state_reg <= RBO_ST_READ;
                    end
                end
                RBO_ST_READ: begin
                    if (mem_ack_i) begin
                        state_reg <= (op_reg == RBO_OP_BIT_TEST) ? RBO_ST_IDLE : RBO_ST_WRITE;
                    end
                end
                RBO_ST_WRITE: begin
                    if (mem_ack_i) begin
                        state_reg <= RBO_ST_IDLE;
                    end
                end
                default: state_reg <= RBO_ST_IDLE;
            endcase
        end
    end

    // captured opcode and bit mask for the memory phases
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            op_reg   <= 8'h00;
            byte_reg <= 8'h00;
        end else if (accept) begin
            op_reg   <= opcode_i;
            byte_reg <= bit_mask;
        end
    end

    // busy covers the whole instruction up to the done pulse
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_o <= 1'b0;
        end else if (accept) begin
            busy_o <= 1'b1;
        end else if (done_o || (state_reg == RBO_ST_IDLE)) begin
            busy_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory port
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_half_o  <= 1'b0;
            mem_lock_o  <= 1'b0;
            mem_addr_o  <= '0;
            mem_wdata_o <= 16'h0000;
        end else if (accept && is_legal && is_ts) begin
            // locked read opens the atomic pair
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b0;
            mem_half_o <= 1'b1;
            mem_lock_o <= 1'b1;
            mem_addr_o <= operand2_i[ADDR_W-1:0];
        end else if (accept && is_legal && is_bit) begin
            // lock held for set and clear so no one slips in between
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b0;
            mem_half_o <= 1'b0;
            mem_lock_o <= (opcode_i != RBO_OP_BIT_TEST);
            mem_addr_o <= byte_addr;
        end else if (mem_req_o && mem_ack_i && (state_reg == RBO_ST_READ)
                     && (op_reg != RBO_OP_BIT_TEST)) begin
            mem_we_o <= 1'b1;
            if (op_reg == RBO_OP_TEST_AND_SET) begin
                mem_wdata_o <= mem_rdata_i | 16'h8000;
            end else if (op_reg == RBO_OP_BIT_SET) begin
                mem_wdata_o <= {8'h00, mem_rdata_i[7:0] | byte_reg};
            end else begin
                mem_wdata_o <= {8'h00, mem_rdata_i[7:0] & ~byte_reg};
            end
        end else if (mem_req_o && mem_ack_i) begin
            mem_req_o  <= 1'b0;
            mem_we_o   <= 1'b0;
            mem_lock_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // completion, register write-back and condition code
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o     <= 1'b0;
            illegal_o  <= 1'b0;
            rf_we_o    <= 1'b0;
            rf_wdata_o <= 32'h0000_0000;
            cc_o       <= 4'h0;
        end else begin
            done_o    <= 1'b0;
            illegal_o <= 1'b0;
            rf_we_o   <= 1'b0;
            if (accept && !is_legal) begin
                done_o    <= 1'b1;
                illegal_o <= 1'b1;
            end else if (accept && (is_rol || is_ror)) begin
                done_o     <= 1'b1;
                rf_we_o    <= 1'b1;
                rf_wdata_o <= rot_res;
                cc_o[RBO_CC_C] <= 1'b0;
                cc_o[RBO_CC_V] <= 1'b0;
                cc_o[RBO_CC_L] <= rot_res[31];
                cc_o[RBO_CC_G] <= !rot_res[31] && (rot_res != 32'h0000_0000);
            end else if ((state_reg == RBO_ST_READ) && mem_ack_i) begin
                if (op_reg == RBO_OP_TEST_AND_SET) begin
                    // old msb into L, others kept
                    cc_o[RBO_CC_L] <= mem_rdata_i[RBO_HALF_MSB];
                end else begin
                    cc_o <= {3'b000, old_bit} << RBO_CC_G;
                end
                done_o <= (op_reg == RBO_OP_BIT_TEST);
            end else if ((state_reg == RBO_ST_WRITE) && mem_ack_i) begin
                done_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_en_reg <= RBO_CTRL_EN_RST;
        end else if (reg_wr_i && (reg_addr_i == RBO_CTRL_OFS)) begin
            ctrl_en_reg <= reg_wdata_i[RBO_CTRL_EN_BIT];
        end
    end

    // sticky refusal flag, write one clears, a new refusal wins over the clear
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ill_sticky_reg <= 1'b0;
        end else if (accept && !is_legal) begin
            ill_sticky_reg <= 1'b1;
        end else if (reg_wr_i && (reg_addr_i == RBO_STATUS_OFS)
                     && reg_wdata_i[RBO_ST_ILL_BIT]) begin
            ill_sticky_reg <= 1'b0;
        end
    end

    // completed instruction count, wraps
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_reg <= 32'h0000_0000;
        end else if (reg_wr_i && (reg_addr_i == RBO_COUNT_OFS)) begin
            count_reg <= reg_wdata_i;
        end else if (done_o && !illegal_o) begin
            count_reg <= count_reg + 32'h0000_0001;
        end
    end

    // read data stands for one cycle only; unmapped reads zero
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                RBO_CTRL_OFS:   reg_rdata_o <= {31'h0000_0000, ctrl_en_reg};
                RBO_STATUS_OFS: reg_rdata_o <= {24'h00_0000, cc_o, 2'b00,
                                                ill_sticky_reg, busy_o};
                RBO_COUNT_OFS:  reg_rdata_o <= count_reg;
                default:        reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_rol_done;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (accept && is_rol && ctrl_en_reg) |=> (done_o && rf_we_o
            && rf_wdata_o == $past(rol_wide[63:32]));
    endproperty
    a_rol_done: assert property (p_rol_done)
        else $error("rotate left did not finish next cycle");
    property p_rol_wrap;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (accept && is_rol && ctrl_en_reg && rot_cnt == 5'd1)
            |=> rf_wdata_o[0] == $past(first_operand_register_i[31]);
    endproperty
    a_rol_wrap: assert property (p_rol_wrap)
        else $error("rotate left lost the wrapped bit");
    property p_ror_wrap;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (accept && is_ror && ctrl_en_reg && rot_cnt == 5'd1)
            |=> rf_wdata_o[31] == $past(first_operand_register_i[0]);
    endproperty
    a_ror_wrap: assert property (p_ror_wrap)
        else $error("rotate right lost the wrapped bit");
    property p_rot_zero;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (accept && (is_rol || is_ror) && ctrl_en_reg && rot_cnt == 5'd0)
            |=> rf_wdata_o == $past(first_operand_register_i);
    endproperty
    a_rot_zero: assert property (p_rot_zero)
        else $error("zero count rotate changed the register");
    property p_rot_cc;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (done_o && rf_we_o) |-> (cc_o[RBO_CC_C] == 1'b0 && cc_o[RBO_CC_V] == 1'b0
            && cc_o[RBO_CC_L] == rf_wdata_o[31]
            && cc_o[RBO_CC_G] == (!rf_wdata_o[31] && rf_wdata_o != 32'h0000_0000));
    endproperty
    a_rot_cc: assert property (p_rot_cc)
        else $error("rotate condition code wrong");
    property p_ts_lock;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (mem_req_o && mem_half_o && !mem_we_o && mem_ack_i)
            |=> (mem_lock_o && mem_we_o && mem_wdata_o[15]
                 && mem_wdata_o[14:0] == $past(mem_rdata_i[14:0]));
    endproperty
    a_ts_lock: assert property (p_ts_lock)
        else $error("test-and-set write-back wrong or unlocked");
    property p_ts_cc;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (state_reg == RBO_ST_READ && mem_ack_i && op_reg == RBO_OP_TEST_AND_SET)
            |=> cc_o[RBO_CC_L] == $past(mem_rdata_i[15]);
    endproperty
    a_ts_cc: assert property (p_ts_cc)
        else $error("test-and-set L flag wrong");
    property p_tbt_nowrite;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (accept && opcode_i == RBO_OP_BIT_TEST && ctrl_en_reg)
            |=> (!mem_we_o && !mem_lock_o && !rf_we_o) throughout (busy_o [*2]);
    endproperty
    a_tbt_nowrite: assert property (p_tbt_nowrite)
        else $error("bit test wrote something");
    property p_bit_cc;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (state_reg == RBO_ST_READ && mem_ack_i && op_reg != RBO_OP_TEST_AND_SET)
            |=> cc_o == ({3'b000, $past(old_bit)} << RBO_CC_G);
    endproperty
    a_bit_cc: assert property (p_bit_cc)
        else $error("bit operation condition code wrong");
    property p_bit_addr;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (accept && is_bit && ctrl_en_reg)
            |=> (mem_req_o && mem_addr_o == $past(byte_addr)
                 && byte_reg == (8'h80 >> $past(first_operand_register_i[2:0])));
    endproperty
    a_bit_addr: assert property (p_bit_addr)
        else $error("bit array address or bit select wrong");
endmodule // rbo_unit

// ---- rbo_mem_model.sv ----
`timescale 1ns/10ps
module rbo_mem_model (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // memory port
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic        mem_half_i,
    input  wire logic [23:0] mem_addr_i,
    input  wire logic [15:0] mem_wdata_i,
    input  wire logic [3:0]  lat_i,
    output logic             mem_ack_o,
    output logic [15:0]      mem_rdata_o
);
    logic [7:0] mem [0:255];
    logic [3:0] wait_cnt;
    logic [7:0] a;
    assign a = mem_addr_i[7:0];
    // small big-endian store, ack after lat_i extra cycles
    // read data toggles outside acks so a stale sample cannot pass
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_cnt <= 4'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 16'h5A5A;
        end else begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i && !mem_ack_o && wait_cnt >= lat_i) begin
                wait_cnt <= 4'h0;
                mem_ack_o <= 1'b1;
                if (mem_we_i && mem_half_i) begin
                    mem[a] <= mem_wdata_i[15:8];
                    mem[a+8'h01] <= mem_wdata_i[7:0];
                end else if (mem_we_i) begin
                    mem[a] <= mem_wdata_i[7:0];
                end else begin
                    mem_rdata_o <= mem_half_i ? {mem[a], mem[a+8'h01]} : {~mem[a], mem[a]};
                end
            end else if (mem_req_i && !mem_ack_o) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule // rbo_mem_model

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
    import rbo_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [7:0] opcode_i = 8'h00;
    logic [31:0] r1 = 32'h0000_0000;
    logic [31:0] op2 = 32'h0000_0000;
    logic busy_o, done_o, illegal_o, rf_we_o, mem_req_o, mem_we_o, mem_half_o, mem_lock_o;
    logic [3:0] cc_o;
    logic [31:0] rf_wdata_o, reg_rdata_o;
    logic [23:0] mem_addr_o;
    logic [15:0] mem_wdata_o, mem_rdata_i;
    logic mem_ack_i;
    logic [3:0] mem_lat = 4'h0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic got_we, got_ill;
    int n_fail = 0;
    int total_checks = 0;
    int n_lock_bad = 0;
    // 250 MHz clock
    always #2 sys_clk_i = ~sys_clk_i;
    rbo_unit uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i),
        .opcode_i(opcode_i), .first_operand_register_i(r1), .operand2_i(op2), .busy_o(busy_o),
        .done_o(done_o), .illegal_o(illegal_o), .cc_o(cc_o), .rf_we_o(rf_we_o),
        .rf_wdata_o(rf_wdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
        .mem_half_o(mem_half_o), .mem_lock_o(mem_lock_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    rbo_mem_model mem (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_half_i(mem_half_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .lat_i(mem_lat), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i));
    // every access but a bit test must stay locked, so the pair is atomic
    always @(negedge sys_clk_i) begin
        if (mem_req_o && (mem_lock_o !== (opcode_i != RBO_OP_BIT_TEST)))
            n_lock_bad++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one instruction, waits for done and then for busy to drop
    task automatic run(input logic [7:0] op, input logic [31:0] a, input logic [31:0] b);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b1;
        opcode_i <= op;
        r1 <= a;
        op2 <= b;
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b0;
        #1;
        while (done_o !== 1'b1 && n < 100) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        got_we = rf_we_o;
        got_ill = illegal_o;
        while (busy_o !== 1'b0 && n < 100) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        if (n >= 100) chk(32'h0000_0000, 32'h0000_0001);
    endtask
    task automatic reg_io(input logic wr, input logic [3:0] ad, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= wr;
        reg_rd_i <= ~wr;
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
    endtask
    function automatic logic [31:0] hw(input int ad);
        return {16'h0000, mem.mem[ad], mem.mem[ad+1]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // examples, masked count, zero count, zero value, count 31 both ways
    task automatic t_rotate();
        logic [7:0] op [9] = '{8'hEB, 8'hEB, 8'hEA, 8'hEA, 8'hEB, 8'hEA, 8'hEB, 8'hEB, 8'hEA};
        logic [31:0] va [9] = '{32'h5678_9ABC, 32'h8888_0000, 32'h1234_5678, 32'h0000_1111,
            32'h8000_0001, 32'hF000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0001};
        logic [31:0] vb [9] = '{32'h0000_0004, 32'h0000_0003, 32'h0000_0004, 32'h0000_0001,
            32'hFFFF_FFE1, 32'h0000_0020, 32'h0000_0005, 32'h0000_001F, 32'h0000_001F};
        logic [31:0] ve [9] = '{32'h6789_ABC5, 32'h4440_0004, 32'h8123_4567, 32'h8000_0888,
            32'h0000_0003, 32'hF000_0000, 32'h0000_0000, 32'h8000_0000, 32'h0000_0002};
        logic [3:0] vc [9] = '{4'h2, 4'h2, 4'h1, 4'h1, 4'h2, 4'h1, 4'h0, 4'h1, 4'h2};
        for (int i = 0; i < 9; i++) begin
            run(op[i], va[i], vb[i]);
            chk(rf_wdata_o, ve[i]);
            chk({28'h0, cc_o}, {28'h0, vc[i]});
            chk({30'h0, got_we, got_ill}, 32'h0000_0002);
        end
    endtask
    // old msb zero then one, slow memory on the second
    task automatic t_test_and_set();
        mem.mem[16] = 8'h31;
        mem.mem[17] = 8'h43;
        mem.mem[18] = 8'h80;
        mem.mem[19] = 8'h01;
        run(RBO_OP_TEST_AND_SET, 32'h0000_0000, 32'h0000_0010);
        chk(hw(16), 32'h0000_B143);
        chk({31'h0, cc_o[RBO_CC_L]}, 32'h0000_0000);
        mem_lat <= 4'h5;
        run(RBO_OP_TEST_AND_SET, 32'h0000_0000, 32'h0000_0012);
        chk(hw(18), 32'h0000_8001);
        chk({31'h0, cc_o[RBO_CC_L]}, 32'h0000_0001);
    endtask
    // bit numbering from msb, crossing into the next byte
    task automatic t_bit_test();
        int off [3] = '{3, 9, 8};
        logic [3:0] vc [3] = '{4'h2, 4'h2, 4'h0};
        mem.mem[32] = 8'hB3;
        mem.mem[33] = 8'h4A;
        for (int i = 0; i < 3; i++) begin
            mem_lat <= 4'(i);
            run(RBO_OP_BIT_TEST, off[i], 32'h0000_0020);
            chk({28'h0, cc_o}, {28'h0, vc[i]});
            chk(hw(32), 32'h0000_B34A);
            chk({31'h0, got_we}, 32'h0000_0000);
        end
    endtask
    // set and clear twice each, far offset, odd base
    task automatic t_bit_write();
        logic [7:0] op [6] = '{8'h75, 8'h75, 8'h76, 8'h76, 8'h75, 8'h75};
        int base [6] = '{48, 48, 64, 64, 80, 65};
        int off [6] = '{8, 8, 3, 3, 23, 1};
        int at [6] = '{48, 48, 64, 64, 82, 64};
        logic [31:0] ve [6] = '{32'h0000_21B4, 32'h0000_21B4, 32'h0000_2143, 32'h0000_2143,
            32'h0000_0100, 32'h0000_2143};
        logic [3:0] vc [6] = '{4'h0, 4'h2, 4'h2, 4'h0, 4'h0, 4'h2};
        mem.mem[48] = 8'h21;
        mem.mem[49] = 8'h34;
        mem.mem[64] = 8'h31;
        mem.mem[65] = 8'h43;
        mem.mem[82] = 8'h00;
        mem.mem[83] = 8'h00;
        for (int i = 0; i < 6; i++) begin
            mem_lat <= 4'(i);
            run(op[i], off[i], base[i]);
            chk(hw(at[i]), ve[i]);
            chk({28'h0, cc_o}, {28'h0, vc[i]});
        end
        chk(n_lock_bad, 32'h0000_0000);
        // preset 0x100 plus twenty legal instructions since then
        reg_io(1'b0, RBO_COUNT_OFS, 32'h0);
        chk(reg_rdata_o, 32'h0000_0114);
    endtask
    // control register reset value, unmapped read, refusals and sticky flag
    task automatic t_regs_illegal();
        reg_io(1'b0, RBO_CTRL_OFS, 32'h0);
        chk(reg_rdata_o, 32'h0000_0001);
        reg_io(1'b0, 4'hC, 32'h0);
        chk(reg_rdata_o, 32'h0000_0000);
        reg_io(1'b1, RBO_COUNT_OFS, 32'h0000_0100);
        run(8'h00, 32'h0000_0001, 32'h0000_0001);
        chk({31'h0, got_ill}, 32'h0000_0001);
        reg_io(1'b0, RBO_STATUS_OFS, 32'h0);
        chk(reg_rdata_o & 32'h0000_0003, 32'h0000_0002);
        reg_io(1'b1, RBO_STATUS_OFS, 32'h0000_0002);
        reg_io(1'b0, RBO_STATUS_OFS, 32'h0);
        chk(reg_rdata_o & 32'h0000_0003, 32'h0000_0000);
        reg_io(1'b1, RBO_CTRL_OFS, 32'h0);
        run(RBO_OP_ROTATE_LEFT, 32'h0000_0001, 32'h0000_0001);
        chk({31'h0, got_ill}, 32'h0000_0001);
        reg_io(1'b1, RBO_CTRL_OFS, 32'h0000_0001);
        reg_io(1'b0, RBO_COUNT_OFS, 32'h0);
        chk(reg_rdata_o, 32'h0000_0100);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_fail++;
        wrap_up();
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        t_regs_illegal();
        t_rotate();
        t_test_and_set();
        t_bit_test();
        t_bit_write();
        wrap_up();
    end
endmodule // testbench
